// ---- core/tdr_pkg.sv ----
// Package of constants and types for the thread dependency register block.
package tdr_pkg;
    // =====================================================================
    // Geometry
    localparam int          TDR_NUM_SLOTS    = 8;
    localparam int          TDR_WORD_W       = 16;
    localparam int          TDR_ID_W         = 8;
    localparam int          TDR_IDX_W        = 3;
    localparam int          TDR_VALID_BIT    = 15;
    // =====================================================================
    // Register addressing
    localparam logic [3:0]  TDR_GROUP_TYPE   = 4'hB;
    localparam logic [3:0]  TDR_GROUP_NUM    = 4'hB;
    localparam logic [4:0]  TDR_SUB_FIRST    = 5'h00;
    localparam logic [4:0]  TDR_SUB_LAST     = 5'h07;
    // =====================================================================
    // Reset values
    localparam logic [7:0]  TDR_ID_RESET     = 8'h00;
    localparam logic [15:0] TDR_READ_RESET   = 16'h0000;
    // =====================================================================
    // Conditional send sequencer states
    typedef enum logic [1:0] {
        TDR_SEND_IDLE = 2'b01,
        TDR_SEND_HOLD = 2'b10
    } tdr_send_state_t;
endpackage

// ---- core/tdr_slot.sv ----
// One thread dependency slot: identifier and valid flag.
`timescale 1ns/100ps
module tdr_slot
    import tdr_pkg::*;
(
    // Clock and reset
    input  wire logic                i_sys_clk,
    input  wire logic                i_nrst,
    input  wire logic                i_ce,
    // Events
    input  wire logic                i_dispatch,
    input  wire logic [7:0]          i_dispatch_id,
    input  wire logic                i_dispatch_valid,
    input  wire logic                i_write_clear,
    input  wire logic                i_retire,
    input  wire logic [7:0]          i_retire_id,
    // State
    output logic      [7:0]          o_id,
    output logic                     o_valid
);
    logic [7:0] next_id;
    logic       next_valid;

    always_comb begin
        next_id    = o_id;
        next_valid = o_valid;
        if (i_write_clear) begin
            next_valid = 1'b0; // RULE9
        end
        if (i_retire && (i_retire_id == o_id)) begin
            next_valid = 1'b0; // RULE7
        end
        // Dispatch loads a new thread context, so it overrides clears of the old one.
        if (i_dispatch) begin
            next_id    = i_dispatch_id;    // RULE8
            next_valid = i_dispatch_valid; // RULE6
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_id    <= TDR_ID_RESET;
            o_valid <= 1'b0; // RULE12
        end else if (i_ce) begin
            o_id    <= next_id;
            o_valid <= next_valid;
        end
    end
endmodule

// ---- core/tdr_regs.sv ----
// Thread dependency register file with conditional send gating.
//
// Functional notes
// RULE1: Eight 16-bit slots, word reads, word write mask.
// RULE2: Group selected when register type nibble is 1011; the code also requires register number nibble 1011.
// RULE3: Subregisters 0..7 map slots; others reserved.
// RULE4: Read: id low byte, zeros, valid bit 15.
// RULE5: Valid set means dependency on stored thread.
// RULE6: Only dispatch sets valid flags.
// RULE7: Matching end-of-thread broadcast clears valid flag.
// RULE8: Identifier changes only on dispatch.
// RULE9: Enabled write clears valid only, data ignored.
// RULE10: Conditional send consults the dependency registers.
// RULE11: Hold conditional send until all valids clear.
// RULE12: Reset clears all valid flags.
`timescale 1ns/100ps
module tdr_regs
    import tdr_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_nrst,
    input  wire logic                          i_ce,
    // Register access port
    input  wire logic [7:0]                    i_register_number_field,
    input  wire logic [4:0]                    i_subregister_number_field,
    input  wire logic                          i_rd_en,
    input  wire logic                          i_wr_en,
    output logic      [15:0]                   o_rd_data,
    output logic                               o_rd_hit,
    // Thread dispatch
    input  wire logic                          i_dispatch,
    input  wire logic [8*8-1:0]                i_dispatch_thread_id,
    input  wire logic [7:0]                    i_dispatch_valid,
    // End-of-thread broadcast
    input  wire logic                          i_eot,
    input  wire logic [7:0]                    i_eot_thread_id,
    // Conditional send
    input  wire logic                          i_sendc_req,
    output logic                               o_sendc_busy,
    output logic                               o_sendc_issue,
    output logic      [7:0]                    o_dep_valid
);
    import tdr_pkg::*;

    // =====================================================================
    // Address decode
    logic                  group_hit;
    logic                  sub_hit;
    logic [TDR_IDX_W-1:0]  slot_idx;
    logic [7:0]            wr_clear;
    logic [7:0]            slot_id [TDR_NUM_SLOTS];

    assign group_hit = (i_register_number_field[7:4] == TDR_GROUP_TYPE) &&
                       (i_register_number_field[3:0] == TDR_GROUP_NUM);   // RULE2
    assign sub_hit   = (i_subregister_number_field >= TDR_SUB_FIRST) &&
                       (i_subregister_number_field <= TDR_SUB_LAST);      // RULE3
    assign slot_idx  = i_subregister_number_field[TDR_IDX_W-1:0];         // RULE3

    // =====================================================================
    // Slots
    genvar g;
    generate
        for (g = 0; g < TDR_NUM_SLOTS; g++) begin : g_slot
            // Word write mask: only the addressed slot is cleared. RULE1
            assign wr_clear[g] = i_wr_en && group_hit && sub_hit && (slot_idx == TDR_IDX_W'(g)); // RULE9
            tdr_slot u_slot (
                .i_sys_clk        (i_sys_clk),
                .i_nrst           (i_nrst),
                .i_ce             (i_ce),
                .i_dispatch       (i_dispatch),
                .i_dispatch_id    (i_dispatch_thread_id[g*8 +: 8]),
                .i_dispatch_valid (i_dispatch_valid[g]),
                .i_write_clear    (wr_clear[g]),
                .i_retire         (i_eot),
                .i_retire_id      (i_eot_thread_id),
                .o_id             (slot_id[g]),
                .o_valid          (o_dep_valid[g])
            );
        end
    endgenerate

    // =====================================================================
    // Read path
    logic [15:0] next_rd_data;
    logic        next_rd_hit;

    always_comb begin
        next_rd_data = o_rd_data;
        next_rd_hit  = 1'b0;
        if (i_rd_en) begin
            next_rd_data = TDR_READ_RESET;
            if (group_hit && sub_hit) begin
                next_rd_hit  = 1'b1;
                // Bits 8..14 stay zero from the reset pattern.
                next_rd_data[TDR_ID_W-1:0]  = slot_id[slot_idx];     // RULE4
                next_rd_data[TDR_VALID_BIT] = o_dep_valid[slot_idx]; // RULE4 RULE5
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_data <= TDR_READ_RESET;
            o_rd_hit  <= 1'b0;
        end else if (i_ce) begin
            o_rd_data <= next_rd_data;
            o_rd_hit  <= next_rd_hit;
        end
    end

    // =====================================================================
    // Conditional send sequencer
    // A held request is re-sampled each cycle; dropping i_sendc_req returns HOLD to IDLE, so the requester must hold it until issue.
    tdr_send_state_t state;
    tdr_send_state_t next_state;
    logic            deps_clear;

    assign deps_clear    = (o_dep_valid == 8'h00);                     // RULE10
    assign o_sendc_issue = i_ce && i_sendc_req && deps_clear;           // RULE11
    assign o_sendc_busy  = (state == TDR_SEND_HOLD);

    always_comb begin
        next_state = state;
        case (state)
            TDR_SEND_IDLE: begin
                if (i_sendc_req && !deps_clear) begin
                    next_state = TDR_SEND_HOLD;                         // RULE11
                end
            end
            TDR_SEND_HOLD: begin
                if (!i_sendc_req || deps_clear) begin
                    next_state = TDR_SEND_IDLE;
                end
            end
            default: begin
                next_state = TDR_SEND_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= TDR_SEND_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end
endmodule

// ---- dv/tdr_regs_props.sv ----
// Checker of port relations for the dependency register block.
`timescale 1ns/100ps
module tdr_regs_props
    import tdr_pkg::*;
(
    input wire logic        i_sys_clk, i_nrst, i_ce, i_rd_en, i_wr_en, i_dispatch, i_sendc_req,
    input wire logic [7:0]  i_register_number_field, i_dispatch_valid, o_dep_valid,
    input wire logic [4:0]  i_subregister_number_field,
    input wire logic        o_sendc_busy, o_sendc_issue, o_rd_hit,
    input wire logic [15:0] o_rd_data
);
    // =====================================================================
    // Assertions
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    wire       hit = i_register_number_field == {TDR_GROUP_TYPE, TDR_GROUP_NUM} && i_subregister_number_field <= 5'h07;
    wire [2:0] s   = i_subregister_number_field[2:0];
    a_read_fmt: assert property (i_ce && i_rd_en && hit |=> o_rd_hit && o_rd_data[14:8] == 7'h00
        && o_rd_data[15] == $past(o_dep_valid[s])) else $error("read word malformed");
    a_miss_zero: assert property (i_ce && i_rd_en && !hit |=> !o_rd_hit && o_rd_data == 16'h0000)
        else $error("reserved read not zero");
    a_write_clr: assert property (i_ce && i_wr_en && hit && !i_dispatch |=> !o_dep_valid[$past(s)])
        else $error("write did not clear valid");
    a_only_disp: assert property ((o_dep_valid & ~$past(o_dep_valid)) != 8'h00 |-> $past(i_dispatch && i_ce))
        else $error("valid set without dispatch");
    a_disp_load: assert property (i_ce && i_dispatch |=> o_dep_valid == $past(i_dispatch_valid))
        else $error("dispatch valids not loaded");
    a_issue_gate: assert property (o_sendc_issue == (i_sendc_req && i_ce && o_dep_valid == 8'h00))
        else $error("send issue gate wrong");
    a_send_hold: assert property (i_sendc_req && i_ce && o_dep_valid != 8'h00 |=> o_sendc_busy)
        else $error("send not held");
    a_reset_clr: assert property ($rose(i_nrst) |-> o_dep_valid == 8'h00 && !o_sendc_busy)
        else $error("state not clear after reset");
    c_send_wait: cover property (o_sendc_busy && o_sendc_issue);
    c_disp_full: cover property (i_dispatch && i_dispatch_valid == 8'hFF);
    c_rd_miss: cover property (i_rd_en && !hit);
endmodule

// ---- dv/tdr_disp_model.sv ----
// Behavioural dispatcher and end-of-thread broadcaster.
`timescale 1ns/100ps
module tdr_disp_model (
    input  wire logic        i_sys_clk,
    output logic             o_dispatch,
    output logic [63:0]      o_ids,
    output logic [7:0]       o_vals,
    output logic             o_eot,
    output logic [7:0]       o_eot_id
);
    // =====================================================================
    // Stimulus tasks
    initial {o_dispatch, o_ids, o_vals, o_eot, o_eot_id} = '0;
    // Released lines carry the inverse so stale values never match the dispatched ones.
    task automatic dispatch(input logic [63:0] ids, input logic [7:0] vals);
        @(posedge i_sys_clk);
        {o_dispatch, o_ids, o_vals} <= {1'b1, ids, vals};
        @(posedge i_sys_clk);
        {o_dispatch, o_ids, o_vals} <= {1'b0, ~ids, ~vals};
    endtask
    task automatic eot(input logic [7:0] id);
        @(posedge i_sys_clk);
        {o_eot, o_eot_id} <= {1'b1, id};
        @(posedge i_sys_clk);
        {o_eot, o_eot_id} <= {1'b0, ~id};
    endtask
endmodule

// ---- dv/tb_tdr_regs.sv ----
// Self-checking bench for the dependency register block.
`timescale 1ns/100ps
module tb_tdr_regs;
    import tdr_pkg::*;
    logic        i_sys_clk = 1'b0, i_nrst = 1'b0, i_rd_en = 1'b0, i_wr_en = 1'b0, i_sendc_req = 1'b0;
    logic [7:0]  i_register_number_field = 8'h00;
    logic [4:0]  i_subregister_number_field = 5'h00;
    logic        i_dispatch, i_eot, o_rd_hit, o_sendc_busy, o_sendc_issue;
    logic [63:0] i_dispatch_thread_id, p;
    logic [7:0]  i_dispatch_valid, i_eot_thread_id, o_dep_valid, vld;
    logic [15:0] o_rd_data, d;
    logic [7:0]  ids [8];
    logic [12:0] res [4] = '{13'h1560, 13'h1740, 13'h1768, 13'h177F};
    int          num_errors = 0, check_count = 0, seed = 32'h65dc, k;
    always #2.5 i_sys_clk = ~i_sys_clk;
    // Clock enable is tied high; freezing is not a documented behaviour.
    tdr_regs dut_u (.i_ce(1'b1), .*);
    tdr_disp_model dm_u (.i_sys_clk(i_sys_clk), .o_dispatch(i_dispatch), .o_ids(i_dispatch_thread_id),
        .o_vals(i_dispatch_valid), .o_eot(i_eot), .o_eot_id(i_eot_thread_id));
    // =====================================================================
    // Tasks
    function automatic logic [15:0] expw(int i);
        return {vld[i], 7'h00, ids[i]};
    endfunction
    task automatic check(input string n, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic acc(input logic [7:0] r, input logic [4:0] s, input logic w);
        @(posedge i_sys_clk);
        {i_register_number_field, i_subregister_number_field, i_rd_en, i_wr_en} <= {r, s, !w, w};
        @(posedge i_sys_clk);
        {i_rd_en, i_wr_en} <= 2'b00;
        #1 d = o_rd_data;
    endtask
    task automatic rdall;
        for (int i = 0; i < 8; i++) begin
            acc(8'hBB, 5'(i), 1'b0);
            check("slot", d, expw(i));
        end
    endtask
    task automatic load(input logic [7:0] v);
        for (int i = 0; i < 8; i++) ids[i] = 8'($random(seed));
        for (int i = 0; i < 8; i++) p[i*8+:8] = ids[i];
        vld = v;
        dm_u.dispatch(p, vld);
    endtask
    // =====================================================================
    // Main sequence
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        vld = 8'h00;
        foreach (ids[i]) ids[i] = TDR_ID_RESET;
        rdall();
        $display("test reset done");
        repeat (6) begin
            load(8'($random(seed)));
            k = $random(seed) & 7;
            acc(8'hBB, 5'(k), 1'b1);
            vld[k] = 1'b0;
            k = $random(seed) & 7;
            dm_u.eot(ids[k]);
            for (int i = 0; i < 8; i++) if (ids[i] == ids[k]) vld[i] = 1'b0;
            rdall();
        end
        $display("test dispatch clear done");
        load(8'hFF);
        foreach (res[i]) begin
            acc(res[i][12:5], res[i][4:0], 1'b1);
            acc(res[i][12:5], res[i][4:0], 1'b0);
            check("reserved", d, 16'h0000);
        end
        rdall();
        $display("test reserved done");
        @(posedge i_sys_clk);
        i_sendc_req <= 1'b1;
        @(posedge i_sys_clk);
        #1 check("busy", 16'(o_sendc_busy), 16'h0001);
        for (int i = 0; i < 8; i++) begin
            acc(8'hBB, 5'(i), 1'b1);
            check("issue", 16'(o_sendc_issue), 16'(i == 7));
        end
        @(posedge i_sys_clk);
        i_sendc_req <= 1'b0;
        $display("test send done");
        wrap_up();
    end
endmodule
bind tdr_regs tdr_regs_props chk_u (.*);
